// File: design/evpd_decoder.sv
// exception vector priority decoder with apb register slave
// Summary of operation
// - base byte is vector upper byte, resets ff
// - reset vectors always at fffa to fffe
// - debug active forces upper byte to ff
// - unmaskable-by-low requests outrank low-mask requests
// - high-mask request preempts low routine if enabled
// - highest vector address wins among eligible
// - low request needs enable, clear mask, quiet
// - priority resolved when core fetches the vector
// - nothing eligible at fetch gives spurious vector
// - reset order: pin/por fffe, clkmon fffc, watchdog fffa
// - trap f8, software interrupt f6, high-mask f4
// - die link f2, low sources f0 down 82
// - every vector is a full 16-bit address
// - low routine nests only after mask cleared
// - base word is base byte then zero byte
// - low request wakes only with low mask clear
`timescale 1ns/10ps
module evpd_decoder
    import evpd_pkg::*;
#(
    parameter int LOW_N = LOW_SRC_NUM
)(
    input wire logic clk,
    input wire logic sys_rst,
    input wire evpd_apb_req_t apbReq,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire evpd_rst_src_t rstSrc,
    input wire evpd_ccr_t coreConditionCodes,
    input wire logic backgroundDebug,
    input wire logic trapReq,
    input wire logic softwareInterrupt,
    input wire logic highMaskReq,
    input wire logic dieLinkInterrupt,
    input wire logic dieLinkEn,
    input wire logic [LOW_N-1:0] lowReq,
    input wire logic [LOW_N-1:0] lowEn,
    input wire logic vecReq,
    output logic [15:0] vecAddr,
    output logic vecValid,
    output logic wakeReq
);

    localparam int IW = $clog2(LOW_N);

    evpd_state_t st;
    evpd_state_t stNext;
    logic encHit;
    logic [IW-1:0] encIdx;
    logic isRst;
    logic lowOk;
    logic dieLinkElig;
    logic [7:0] selLow;
    logic [7:0] vectorUpperByte;
    logic [15:0] baseWord;
    logic [15:0] selVec;
    logic fetch;
    logic apbAccess;

    evpd_prio_enc #(
        .N(LOW_N)
    ) u_enc (
        .req(lowReq),
        .en(lowEn),
        .hit(encHit),
        .idx(encIdx)
    );

    // ----------------------------------------------------------------
    // priority selection
    // ----------------------------------------------------------------
    always_comb
    begin
        isRst = 1'b1;
        // low requests stay out while anything unmaskable-by-low waits
        lowOk = !coreConditionCodes.lowMask & !trapReq &
            !softwareInterrupt & !highMaskReq;
        dieLinkElig = dieLinkInterrupt & dieLinkEn;
        // fixed descending chain: higher address tested first
        if (rstSrc.pinPor)
            selLow = VEC_RST_POR;
        else if (rstSrc.clkMon)
            selLow = VEC_RST_CLKMON;
        else if (rstSrc.watchdog)
            selLow = VEC_RST_WDOG;
        else
        begin
            isRst = 1'b0;
            if (trapReq)
                selLow = VEC_TRAP;
            else if (softwareInterrupt)
                selLow = VEC_SWI;
            else if (highMaskReq & !coreConditionCodes.highMask)
                selLow = VEC_HIGH;
            else if (lowOk & dieLinkElig)
                selLow = VEC_DIE_LINK;
            else if (lowOk & encHit)
                selLow = 8'(VEC_LOW_FIRST + {encIdx, 1'b0});
            else
                // a request dropped before fetch lands here
                selLow = VEC_SPURIOUS;
        end
        // resets ignore the programmed base
        if (isRst | backgroundDebug)
            vectorUpperByte = FIXED_UPPER;
        else
            vectorUpperByte = st.base;
        baseWord = {vectorUpperByte, BASE_LOW_BYTE};
        selVec = baseWord + {8'h00, selLow};
    end

    assign fetch = vecReq & !st.vecValid;
    assign apbAccess = apbReq.psel & apbReq.penable;

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        stNext = st;
        // resolved only now, so a late winner replaces the trigger
        if (fetch)
        begin
            stNext.vec = selVec;
            stNext.vecValid = 1'b1;
        end
        else if (!vecReq)
            stNext.vecValid = 1'b0;
        // only async-asserted sources can wake from stop; not handled
        stNext.wake = !coreConditionCodes.lowMask &
            (encHit | dieLinkElig);
        // one wait state: data loaded first, write done at completion
        if (apbAccess & !st.pready)
        begin
            stNext.pready = 1'b1;
            stNext.pslverr = 1'b0;
            stNext.prdata = 32'h0000_0000;
            if (apbReq.paddr == OFS_VECTOR_BASE)
                stNext.prdata[7:0] = st.base;
            else if (apbReq.paddr == OFS_STATUS)
            begin
                stNext.prdata[STS_VALID_BIT] = st.vecValid;
                stNext.prdata[STS_DEBUG_BIT] = backgroundDebug;
                stNext.prdata[STS_VEC_LSB +: 16] = st.vec;
            end
            else
                stNext.pslverr = 1'b1;
        end
        else if (apbAccess & st.pready)
        begin
            stNext.pready = 1'b0;
            stNext.pslverr = 1'b0;
            if (apbReq.pwrite & apbReq.paddr == OFS_VECTOR_BASE)
                stNext.base = apbReq.pwdata[7:0];
        end
        else
        begin
            stNext.pready = 1'b0;
            stNext.pslverr = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            st.base <= VECTOR_BASE_RST;
            st.vec <= {FIXED_UPPER, VEC_RST_POR};
            st.vecValid <= 1'b0;
            st.wake <= 1'b0;
            st.pready <= 1'b0;
            st.pslverr <= 1'b0;
            st.prdata <= 32'h0000_0000;
        end
        else
            st <= stNext;
    end

    assign prdata = st.prdata;
    assign pready = st.pready;
    assign pslverr = st.pslverr;
    assign vecAddr = st.vec;
    assign vecValid = st.vecValid;
    assign wakeReq = st.wake;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    logic anyRst;
    logic quiet;
    assign anyRst = rstSrc.pinPor | rstSrc.clkMon | rstSrc.watchdog;
    assign quiet = !anyRst & !trapReq & !softwareInterrupt;

    chk_base_write: assert property (
        apbAccess & st.pready & apbReq.pwrite &
        apbReq.paddr == OFS_VECTOR_BASE
        |=> st.base == $past(apbReq.pwdata[7:0]) ##1
            (!apbAccess || st.base == $past(st.base)))
        else $error("base write not stored");

    chk_por_vec: assert property (
        fetch & rstSrc.pinPor |=> vecAddr == 16'hfffe & vecValid)
        else $error("reset vector wrong");

    chk_clkmon_vec: assert property (
        fetch & !rstSrc.pinPor & rstSrc.clkMon
        |=> vecAddr == 16'hfffc)
        else $error("clock monitor vector wrong");

    chk_debug_upper: assert property (
        fetch & backgroundDebug |=> vecAddr[15:8] == FIXED_UPPER)
        else $error("debug upper byte not forced");

    chk_trap_vec: assert property (
        fetch & !anyRst & trapReq & !backgroundDebug
        |=> vecAddr == {st.base, VEC_TRAP})
        else $error("trap vector wrong");

    chk_high_preempt: assert property (
        fetch & quiet & highMaskReq & !coreConditionCodes.highMask
        |=> vecAddr[7:0] == VEC_HIGH)
        else $error("high mask request not chosen");

    chk_low_masked: assert property (
        fetch & quiet & !highMaskReq & coreConditionCodes.lowMask
        |=> vecAddr[7:0] == VEC_SPURIOUS)
        else $error("masked low request served");

    chk_spurious_vec: assert property (
        fetch & quiet & !highMaskReq & !dieLinkElig & !(|(lowReq & lowEn))
        |=> vecAddr[7:0] == VEC_SPURIOUS)
        else $error("spurious vector missing");

    chk_hold_vec: assert property (
        vecValid & vecReq |=> vecValid & $stable(vecAddr))
        else $error("vector changed during fetch");

    chk_wake_gate: assert property (
        coreConditionCodes.lowMask |=> !wakeReq)
        else $error("wake with low mask set");

    // ----------------------------------------------------------------
    // further vector checks
    // ----------------------------------------------------------------
    logic lowPath;
    logic lowAny;
    assign lowPath = quiet & !highMaskReq & !coreConditionCodes.lowMask;
    assign lowAny = |(lowReq & lowEn);

    chk_wdog_vec: assert property (
        fetch & !rstSrc.pinPor & !rstSrc.clkMon & rstSrc.watchdog
        |=> vecAddr == 16'hfffa)
        else $error("watchdog vector wrong");

    chk_swi_vec: assert property (
        fetch & !anyRst & !trapReq & softwareInterrupt
        |=> vecAddr[7:0] == VEC_SWI)
        else $error("software interrupt vector wrong");

    chk_nonlow_rank: assert property (
        fetch & !anyRst & (trapReq | softwareInterrupt |
            highMaskReq & !coreConditionCodes.highMask)
        |=> vecAddr[7:0] >= VEC_HIGH)
        else $error("low request outranked a higher one");

    chk_die_link: assert property (
        fetch & lowPath & dieLinkElig |=> vecAddr[7:0] == VEC_DIE_LINK)
        else $error("die link vector wrong");

    chk_low_range: assert property (
        fetch & lowPath & !dieLinkElig & lowAny
        |=> vecAddr[7:0] >= VEC_LOW_FIRST & vecAddr[7:0] < VEC_DIE_LINK &
            !vecAddr[0])
        else $error("low vector out of range");

    chk_low_top: assert property (
        fetch & lowPath & !dieLinkElig & lowReq[LOW_N-1] & lowEn[LOW_N-1]
        |=> vecAddr[7:0] == 8'(VEC_LOW_FIRST + 2 * (LOW_N - 1)))
        else $error("highest low source not chosen");

    chk_base_upper: assert property (
        fetch & !anyRst & !backgroundDebug
        |=> vecAddr[15:8] == $past(st.base))
        else $error("upper byte is not the base");

    chk_rst_upper: assert property (
        fetch & anyRst |=> vecAddr[15:8] == FIXED_UPPER)
        else $error("reset vector left the top page");

    chk_vec_even: assert property (
        vecValid |-> !vecAddr[0])
        else $error("odd vector address");

    chk_valid_rise: assert property (
        fetch |=> vecValid)
        else $error("vector not answered");

    chk_valid_drop: assert property (
        vecValid & !vecReq |=> !vecValid)
        else $error("vector valid outlived request");

    // ----------------------------------------------------------------
    // register bus and wake checks
    // ----------------------------------------------------------------
    chk_one_wait: assert property (
        apbAccess & !pready |=> pready)
        else $error("bus answer not after one wait state");

    chk_ready_pulse: assert property (
        pready |=> !pready)
        else $error("bus ready held too long");

    chk_unmapped_err: assert property (
        apbAccess & !pready & apbReq.paddr != OFS_VECTOR_BASE &
        apbReq.paddr != OFS_STATUS
        |=> pready & pslverr & prdata == 32'h0000_0000)
        else $error("unmapped access not refused");

    chk_wake_set: assert property (
        !coreConditionCodes.lowMask & (lowAny | dieLinkElig) |=> wakeReq)
        else $error("enabled low request did not wake");

    cov_reset_fetch: cover property (fetch & rstSrc.watchdog ##1 vecValid);
    cov_low_fetch: cover property (fetch & quiet & lowOk & encHit);
    cov_spurious: cover property (vecValid && vecAddr[7:0] == VEC_SPURIOUS);
    cov_debug_fetch: cover property (fetch & backgroundDebug & !anyRst);
    cov_base_write: cover property (apbAccess & st.pready & apbReq.pwrite);

endmodule : evpd_decoder

// File: design/evpd_pkg.sv
// shared constants and types of the exception vector priority decoder
package evpd_pkg;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] OFS_VECTOR_BASE = 8'h00;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] VECTOR_BASE_RST = 8'hff;
    localparam int STS_VALID_BIT = 0;
    localparam int STS_DEBUG_BIT = 1;
    localparam int STS_VEC_LSB = 16;

    // ----------------------------------------------------------------
    // vector layout
    // ----------------------------------------------------------------
    localparam logic [7:0] FIXED_UPPER = 8'hff;
    localparam logic [7:0] BASE_LOW_BYTE = 8'h00;
    localparam logic [7:0] VEC_RST_POR = 8'hfe;
    localparam logic [7:0] VEC_RST_CLKMON = 8'hfc;
    localparam logic [7:0] VEC_RST_WDOG = 8'hfa;
    localparam logic [7:0] VEC_TRAP = 8'hf8;
    localparam logic [7:0] VEC_SWI = 8'hf6;
    localparam logic [7:0] VEC_HIGH = 8'hf4;
    localparam logic [7:0] VEC_DIE_LINK = 8'hf2;
    localparam logic [7:0] VEC_LOW_FIRST = 8'h82;
    localparam logic [7:0] VEC_SPURIOUS = 8'h80;
    localparam int LOW_SRC_NUM = 56;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_AW-1:0] paddr;
        logic [31:0] pwdata;
    } evpd_apb_req_t;

    typedef struct packed {
        logic pinPor;
        logic clkMon;
        logic watchdog;
    } evpd_rst_src_t;

    typedef struct packed {
        logic lowMask;
        logic highMask;
    } evpd_ccr_t;

    typedef struct packed {
        logic [7:0] base;
        logic [15:0] vec;
        logic vecValid;
        logic wake;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
    } evpd_state_t;

endpackage : evpd_pkg

// File: design/evpd_prio_enc.sv
// highest-index finder for the low-priority-mask sources
`timescale 1ns/10ps
module evpd_prio_enc
    import evpd_pkg::*;
#(
    parameter int N = LOW_SRC_NUM
)(
    input wire logic [N-1:0] req,
    input wire logic [N-1:0] en,
    output logic hit,
    output logic [$clog2(N)-1:0] idx
);

    logic [N-1:0] elig;

    // ----------------------------------------------------------------
    // local enable gate per source
    // ----------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : gen_elig
            assign elig[g] = req[g] & en[g];
        end
    endgenerate

    // ----------------------------------------------------------------
    // higher index means higher vector address, so it wins
    // ----------------------------------------------------------------
    always_comb
    begin
        hit = 1'b0;
        idx = '0;
        for (int i = 0; i < N; i++)
        begin
            if (elig[i])
            begin
                hit = 1'b1;
                idx = i[$clog2(N)-1:0];
            end
        end
    end

endmodule : evpd_prio_enc

// File: verif/evpd_core_model.sv
// behavioural core that fetches exception vectors from the decoder
`timescale 1ns/10ps
module evpd_core_model
    import evpd_pkg::*;
(
    input wire logic clk,
    input wire logic vecValid,
    input wire logic [15:0] vecAddr,
    output logic vecReq
);
    initial vecReq = 1'b0;

    // ----------------------------------------------------------------
    // fetch: raise, wait bounded, hold, release, see valid fall
    // ----------------------------------------------------------------
    task automatic fetch(input int hold, output logic [15:0] addr,
        output bit ok);
        int n;
        n = 0;
        ok = 1'b1;
        @(posedge clk);
        vecReq <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (vecValid !== 1'b1 && n < 20);
        if (vecValid !== 1'b1) ok = 1'b0;
        addr = vecAddr;
        // slow core: vector must stay put while strobe is held
        repeat (hold)
        begin
            @(posedge clk);
            if (vecValid !== 1'b1 || vecAddr !== addr) ok = 1'b0;
        end
        vecReq <= 1'b0;
        repeat (2) @(posedge clk);
        if (vecValid !== 1'b0) ok = 1'b0;
    endtask : fetch
endmodule : evpd_core_model

// File: verif/evpd_decoder_tb_top.sv
// self-checking testbench of the exception vector priority decoder
`timescale 1ns/10ps
module evpd_decoder_tb_top
    import evpd_pkg::*;
;
    localparam int LN = 4;
    logic clk;
    logic sys_rst;
    evpd_apb_req_t apbReq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    evpd_rst_src_t rstSrc;
    evpd_ccr_t coreConditionCodes;
    logic backgroundDebug;
    logic trapReq;
    logic softwareInterrupt;
    logic highMaskReq;
    logic dieLinkInterrupt;
    logic dieLinkEn;
    logic [LN-1:0] lowReq;
    logic [LN-1:0] lowEn;
    logic vecReq;
    logic [15:0] vecAddr;
    logic vecValid;
    logic wakeReq;
    logic [31:0] rd;
    logic err;
    int errCount;
    int checkCount;

    evpd_decoder #(.LOW_N(LN)) i_dut (
        .clk(clk), .sys_rst(sys_rst), .apbReq(apbReq), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rstSrc(rstSrc),
        .coreConditionCodes(coreConditionCodes),
        .backgroundDebug(backgroundDebug), .trapReq(trapReq),
        .softwareInterrupt(softwareInterrupt), .highMaskReq(highMaskReq),
        .dieLinkInterrupt(dieLinkInterrupt), .dieLinkEn(dieLinkEn),
        .lowReq(lowReq), .lowEn(lowEn), .vecReq(vecReq),
        .vecAddr(vecAddr), .vecValid(vecValid), .wakeReq(wakeReq)
    );
    evpd_core_model i_core (
        .clk(clk), .vecValid(vecValid), .vecAddr(vecAddr), .vecReq(vecReq)
    );

    always #4 clk = ~clk;

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic giveVerdict();
        $display("checks %0d errors %0d", checkCount, errCount);
        if (errCount == 0 && checkCount > 0)
        begin
            $display("SIMULATION PASSED");
        end
        else
        begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : giveVerdict

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checkCount++;
        if (got !== exp)
        begin
            errCount++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        @(posedge clk);
        apbReq.psel <= 1'b1;
        apbReq.pwrite <= wr;
        apbReq.paddr <= a;
        apbReq.pwdata <= d;
        @(posedge clk);
        apbReq.penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        apbReq.psel <= 1'b0;
        apbReq.penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            errCount++;
            giveVerdict();
        end
    endtask : apb

    task automatic readBase(input logic [31:0] exp);
        apb(1'b0, OFS_VECTOR_BASE, 32'h0, rd, err);
        cmp(rd, exp);
    endtask : readBase

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic try(input logic [2:0] rs, input logic [3:0] src,
        input logic [3:0] lr, input logic [3:0] le, input logic [1:0] cc,
        input logic dbg, input logic [15:0] expVec, input logic expWake);
        logic [15:0] got;
        bit ok;
        @(posedge clk);
        rstSrc <= rs;
        {trapReq, softwareInterrupt, highMaskReq, dieLinkInterrupt} <= src;
        lowReq <= lr;
        lowEn <= le;
        coreConditionCodes <= cc;
        backgroundDebug <= dbg;
        repeat (2) @(posedge clk);
        cmp({31'h0, wakeReq}, {31'h0, expWake});
        i_core.fetch(2, got, ok); // requests held
        cmp({15'h0, ok, got}, {16'h0001, expVec});
    endtask : try

    // inputs change on the same edge as the strobe rises and again while held
    task automatic lateChange(input logic toTrap, input logic [15:0] exp);
        logic [15:0] got;
        bit ok;
        try(3'b000, 4'h0, 4'h8, 4'hf, 2'b00, 1'b0, 16'h1288, 1'b1);
        fork
            i_core.fetch(4, got, ok);
            begin
                @(posedge clk);
                trapReq <= toTrap;
                lowReq <= 4'h0;
                repeat (3) @(posedge clk);
                softwareInterrupt <= 1'b1;
            end
        join
        trapReq <= 1'b0;
        softwareInterrupt <= 1'b0;
        cmp({15'h0, ok, got}, {16'h0001, exp});
    endtask : lateChange

    initial
    begin
        #800000;
        errCount++;
        giveVerdict();
    end

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        apbReq = '0;
        rstSrc = '0;
        coreConditionCodes = 2'b11;
        {backgroundDebug, trapReq, softwareInterrupt} = 3'b000;
        {highMaskReq, dieLinkInterrupt, dieLinkEn} = 3'b001;
        lowReq = '0;
        lowEn = '0;
        errCount = 0;
        checkCount = 0;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        readBase(32'h0000_00ff);
        try(3'b000, 4'h0, 4'h0, 4'h0, 2'b11, 1'b0, 16'hff80,
            1'b0);
        apb(1'b1, OFS_VECTOR_BASE, 32'h0000_0012, rd, err);
        try(3'b111, 4'hf, 4'hf, 4'hf, 2'b10, 1'b0, 16'hfffe,
            1'b0);
        // enabled low requests with the low mask clear always wake
        try(3'b011, 4'hf, 4'hf, 4'hf, 2'b00, 1'b0, 16'hfffc,
            1'b1);
        try(3'b001, 4'hf, 4'hf, 4'hf, 2'b00, 1'b0, 16'hfffa,
            1'b1);
        try(3'b000, 4'hf, 4'hf, 4'hf, 2'b00, 1'b0, 16'h12f8,
            1'b1);
        try(3'b000, 4'h7, 4'hf, 4'hf, 2'b00, 1'b0, 16'h12f6,
            1'b1);
        try(3'b000, 4'h3, 4'hf, 4'hf, 2'b00, 1'b0, 16'h12f4,
            1'b1);
        try(3'b000, 4'h3, 4'hf, 4'hf, 2'b01, 1'b0, 16'h1280,
            1'b1);
        try(3'b000, 4'h1, 4'hf, 4'hf, 2'b00, 1'b0, 16'h12f2,
            1'b1);
        try(3'b000, 4'h0, 4'ha, 4'hf, 2'b00, 1'b0, 16'h1288,
            1'b1);
        try(3'b000, 4'h0, 4'h3, 4'hf, 2'b00, 1'b0, 16'h1284,
            1'b1);
        try(3'b000, 4'h0, 4'ha, 4'h5, 2'b00, 1'b0, 16'h1280,
            1'b0);
        try(3'b000, 4'h0, 4'ha, 4'hf, 2'b10, 1'b0, 16'h1280,
            1'b0);
        try(3'b000, 4'h4, 4'h0, 4'hf, 2'b00, 1'b1, 16'hfff6,
            1'b0);
        try(3'b000, 4'h0, 4'h8, 4'hf, 2'b00, 1'b1, 16'hff88,
            1'b1);
        lateChange(1'b1, 16'h12f8);
        lateChange(1'b0, 16'h1280);
        // status shows the last vector, valid and debug both low
        apb(1'b0, OFS_STATUS, 32'h0, rd, err);
        cmp(rd, 32'h1280_0000);
        cmp({31'h0, err}, 32'h0);
        apb(1'b1, OFS_STATUS, 32'h0000_0034, rd, err);
        cmp({31'h0, err}, 32'h0);
        apb(1'b0, 8'h08, 32'h0, rd, err);
        cmp({err, rd[30:0]}, 32'h8000_0000);
        apb(1'b1, 8'h08, 32'h0000_0034, rd, err);
        cmp({31'h0, err}, 32'h1);
        readBase(32'h0000_0012);
        // second reset mid-run must bring the table home again
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        cmp({15'h0, vecValid, vecAddr}, 32'h0000_fffe);
        readBase(32'h0000_00ff);
        giveVerdict();
    end
endmodule : evpd_decoder_tb_top
